// [design/btc_pkg.sv]
`default_nettype none
package btc_pkg;
   // ---------------------------------------------------------------
   // Field positions of the 32-bit instruction word
   // ---------------------------------------------------------------
   localparam int OP_MSB = 31;
   localparam int OP_LSB = 26;
   localparam int FS_MSB = 25;
   localparam int FS_LSB = 21;
   localparam int SS_MSB = 20;
   localparam int SS_LSB = 16;
   localparam int RD_MSB = 15;
   localparam int RD_LSB = 11;
   localparam int FUNCT_MSB = 5;
   localparam int CODE_MSB = 25;
   localparam int CODE_LSB = 6;
   localparam int OFFS_MSB = 15;
   localparam int CO_BIT = 25;
   localparam int COFUN_MSB = 24;
   localparam int CPSEL_MSB = 27;
   localparam int CPSEL_LSB = 26;
   // ---------------------------------------------------------------
   // Major opcodes
   // ---------------------------------------------------------------
   localparam logic [5:0] OP_SPECIAL = 6'h00;
   localparam logic [5:0] OP_REGIMM = 6'h01;
   localparam logic [5:0] OP_EQ_LIKELY = 6'h14;
   localparam logic [5:0] OP_NE_LIKELY = 6'h15;
   localparam logic [5:0] OP_LEZ_LIKELY = 6'h16;
   localparam logic [5:0] OP_GTZ_LIKELY = 6'h17;
   localparam logic [3:0] OP_COPROC_HI = 4'h4;
   // ---------------------------------------------------------------
   // Sub-codes: register-immediate selector, trap functions, coproc
   // ---------------------------------------------------------------
   localparam logic [4:0] RI_LTZ_LIKELY = 5'h02;
   localparam logic [4:0] RI_GEZ_LIKELY = 5'h03;
   localparam logic [4:0] RI_LTZ_LINK_LIKELY = 5'h12;
   localparam logic [4:0] RI_GEZ_LINK_LIKELY = 5'h13;
   localparam logic [5:0] FN_SYSTEM_CALL_TRAP = 6'h0C;
   localparam logic [5:0] FN_BREAK = 6'h0D;
   localparam logic [5:0] FN_DEBUG_BREAK = 6'h0E;
   localparam logic [4:0] CP_MOVE_FROM_DATA = 5'h00;
   localparam logic [4:0] CP_MOVE_FROM_CTRL = 5'h02;
   localparam logic [4:0] CP_MOVE_TO_DATA = 5'h04;
   localparam logic [4:0] CP_MOVE_TO_CTRL = 5'h06;
   localparam logic [4:0] CP_BRANCH = 5'h08;
   localparam logic [4:0] CP_BR_FALSE = 5'h00;
   localparam logic [4:0] CP_BR_TRUE = 5'h01;
   // ---------------------------------------------------------------
   // Address arithmetic and reset values
   // ---------------------------------------------------------------
   localparam logic [31:0] SLOT_STEP = 32'h0000_0004;
   localparam logic [31:0] LINK_STEP = 32'h0000_0008;
   localparam logic [4:0] LINK_REGISTER = 5'h1F;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;
endpackage
`default_nettype wire

// [design/btc_exec.sv]
`default_nettype none
module btc_exec #(
   parameter int NUM_CP = 4
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic INSTR_VALID,
   input wire logic [31:0] INSTR_WORD,
   input wire logic [31:0] INSTR_ADDR,
   input wire logic [31:0] FIRST_SRC_DATA,
   input wire logic [31:0] SECOND_SRC_DATA,
   input wire logic [NUM_CP-1:0] CP_COND,
   input wire logic [31:0] CP_RDATA,
   output logic INSTR_READY,
   output logic BRANCH_TAKEN,
   output logic [31:0] BRANCH_TARGET,
   output logic NULLIFY_SLOT,
   output logic GPR_WE,
   output logic [4:0] GPR_WADDR,
   output logic [31:0] GPR_WDATA,
   output logic EXC_SYSTEM_CALL_TRAP,
   output logic EXC_BREAKPOINT,
   output logic EXC_DEBUG,
   output logic [19:0] TRAP_CODE,
   output logic [1:0] CP_SEL,
   output logic [4:0] CP_REG,
   output logic CP_DATA_WE,
   output logic CP_CTRL_WE,
   output logic CP_DATA_RE,
   output logic CP_CTRL_RE,
   output logic [31:0] CP_WDATA,
   output logic CP_OP_VALID,
   output logic [24:0] CP_OP
);

   // ---------------------------------------------------------------
   // Elaboration check
   // ---------------------------------------------------------------
   // The select field is two bits wide, so at most four coprocessors
   if (NUM_CP < 1 || NUM_CP > 4) begin : g_bad_num_cp
      $error("NUM_CP must lie between 1 and 4");
   end

   // ---------------------------------------------------------------
   // Helper functions
   // ---------------------------------------------------------------
   // Slot address plus word offset, sign-extended from 16 bits
   function automatic logic [31:0] branch_dest(input logic [31:0] addr,
                                               input logic [15:0] offs);
      logic [31:0] wide;
      wide = {{14{offs[15]}}, offs, 2'b00};
      branch_dest = addr + btc_pkg::SLOT_STEP + wide;
   endfunction

   // Signed zero comparisons on the first source register
   function automatic logic is_neg(input logic [31:0] v);
      is_neg = v[31];
   endfunction

   function automatic logic is_zero(input logic [31:0] v);
      is_zero = (v == btc_pkg::RESET_WORD);
   endfunction

   // ---------------------------------------------------------------
   // Field extraction
   // ---------------------------------------------------------------
   logic [5:0] op, funct;
   logic [4:0] fs, ss, rd_field;
   logic [15:0] offs;
   logic [1:0] sel;
   logic sel_ok, is_cop, cond_now;
   logic [31:0] dest;

   // Plain slices of the word under decode, then the unit check and branch target
   assign op = INSTR_WORD[btc_pkg::OP_MSB:btc_pkg::OP_LSB];
   assign fs = INSTR_WORD[btc_pkg::FS_MSB:btc_pkg::FS_LSB];
   assign ss = INSTR_WORD[btc_pkg::SS_MSB:btc_pkg::SS_LSB];
   assign rd_field = INSTR_WORD[btc_pkg::RD_MSB:btc_pkg::RD_LSB];
   assign funct = INSTR_WORD[btc_pkg::FUNCT_MSB:0];
   assign offs = INSTR_WORD[btc_pkg::OFFS_MSB:0];
   assign sel = INSTR_WORD[btc_pkg::CPSEL_MSB:btc_pkg::CPSEL_LSB];
   assign sel_ok = (32'(sel) < 32'(NUM_CP));
   assign is_cop = (op[5:2] == btc_pkg::OP_COPROC_HI) && sel_ok;
   assign dest = branch_dest(INSTR_ADDR, offs);

   // Condition line of the selected unit, read in the decode cycle
   // so the coprocessor must hold it valid while the branch decodes
   always_comb begin
      cond_now = 1'b0;
      for (int i = 0; i < NUM_CP; i++) begin
         if (32'(sel) == i) begin
            cond_now = CP_COND[i];
         end
      end
   end

   // ---------------------------------------------------------------
   // Registered outputs and pending coprocessor read
   // ---------------------------------------------------------------
   logic rd_pend, next_rd_pend, take;
   logic next_branch_taken, next_nullify_slot, next_gpr_we;
   logic next_exc_system_call_trap, next_exc_breakpoint, next_exc_debug;
   logic next_cp_data_we, next_cp_ctrl_we, next_cp_data_re;
   logic next_cp_ctrl_re, next_cp_op_valid;
   logic [31:0] next_branch_target, next_gpr_wdata, next_cp_wdata;
   logic [4:0] next_gpr_waddr, next_cp_reg, rd_target, next_rd_target;
   logic [19:0] next_trap_code;
   logic [1:0] next_cp_sel;
   logic [24:0] next_cp_op;

   // A read from a coprocessor takes two cycles, so decode stalls once
   assign INSTR_READY = !rd_pend;

   // Decode and execute; every strobe is a one-cycle pulse, data outputs keep their last value
   always_comb begin
      take = 1'b0;
      next_rd_pend = 1'b0;
      next_rd_target = rd_target;
      next_branch_taken = 1'b0;
      next_branch_target = BRANCH_TARGET;
      next_nullify_slot = 1'b0;
      next_gpr_we = 1'b0;
      next_gpr_waddr = GPR_WADDR;
      next_gpr_wdata = GPR_WDATA;
      next_exc_system_call_trap = 1'b0;
      next_exc_breakpoint = 1'b0;
      next_exc_debug = 1'b0;
      next_trap_code = TRAP_CODE;
      next_cp_sel = CP_SEL;
      next_cp_reg = CP_REG;
      next_cp_data_we = 1'b0;
      next_cp_ctrl_we = 1'b0;
      next_cp_data_re = 1'b0;
      next_cp_ctrl_re = 1'b0;
      next_cp_wdata = CP_WDATA;
      next_cp_op_valid = 1'b0;
      next_cp_op = CP_OP;
      if (rd_pend) begin
         // Coprocessor answers in the read cycle; land it in the GPR
         next_gpr_we = 1'b1;
         next_gpr_waddr = rd_target;
         next_gpr_wdata = CP_RDATA;
      end else if (INSTR_VALID) begin
         case (op)
            btc_pkg::OP_EQ_LIKELY, btc_pkg::OP_NE_LIKELY: begin
               take = (op == btc_pkg::OP_EQ_LIKELY) ?
                      (FIRST_SRC_DATA == SECOND_SRC_DATA) :
                      (FIRST_SRC_DATA != SECOND_SRC_DATA);
               next_branch_taken = take;
               next_branch_target = dest;
               next_nullify_slot = !take;
            end
            btc_pkg::OP_LEZ_LIKELY, btc_pkg::OP_GTZ_LIKELY: begin
               take = is_neg(FIRST_SRC_DATA) ||
                      is_zero(FIRST_SRC_DATA);
               if (op == btc_pkg::OP_GTZ_LIKELY) begin
                  take = !take;
               end
               next_branch_taken = take;
               next_branch_target = dest;
               next_nullify_slot = !take;
            end
            btc_pkg::OP_REGIMM: begin
               case (ss)
                  btc_pkg::RI_LTZ_LIKELY,
                  btc_pkg::RI_LTZ_LINK_LIKELY: begin
                     take = is_neg(FIRST_SRC_DATA);
                     next_branch_taken = take;
                     next_branch_target = dest;
                     next_nullify_slot = !take;
                  end
                  btc_pkg::RI_GEZ_LIKELY,
                  btc_pkg::RI_GEZ_LINK_LIKELY: begin
                     take = !is_neg(FIRST_SRC_DATA);
                     next_branch_taken = take;
                     next_branch_target = dest;
                     next_nullify_slot = !take;
                  end
                  default: begin
                     take = 1'b0;
                  end
               endcase
               // Link is written even when the branch falls through
               if (ss == btc_pkg::RI_LTZ_LINK_LIKELY ||
                   ss == btc_pkg::RI_GEZ_LINK_LIKELY) begin
                  next_gpr_we = 1'b1;
                  next_gpr_waddr = btc_pkg::LINK_REGISTER;
                  next_gpr_wdata = INSTR_ADDR + btc_pkg::LINK_STEP;
               end
            end
            btc_pkg::OP_SPECIAL: begin
               // Register-format traps carry a 20-bit code field
               if (funct == btc_pkg::FN_SYSTEM_CALL_TRAP) begin
                  next_exc_system_call_trap = 1'b1;
               end
               if (funct == btc_pkg::FN_BREAK) begin
                  next_exc_breakpoint = 1'b1;
               end
               if (funct == btc_pkg::FN_DEBUG_BREAK) begin
                  next_exc_debug = 1'b1;
               end
               if (funct == btc_pkg::FN_SYSTEM_CALL_TRAP ||
                   funct == btc_pkg::FN_BREAK ||
                   funct == btc_pkg::FN_DEBUG_BREAK) begin
                  next_trap_code =
                     INSTR_WORD[btc_pkg::CODE_MSB:btc_pkg::CODE_LSB];
               end
            end
            default: begin
               if (is_cop && INSTR_WORD[btc_pkg::CO_BIT]) begin
                  // Operation leaves every core output idle
                  next_cp_sel = sel;
                  next_cp_op_valid = 1'b1;
                  next_cp_op = INSTR_WORD[btc_pkg::COFUN_MSB:0];
               end else if (is_cop) begin
                  case (fs)
                     btc_pkg::CP_MOVE_TO_DATA: begin
                        next_cp_sel = sel;
                        next_cp_reg = rd_field;
                        next_cp_wdata = SECOND_SRC_DATA;
                        next_cp_data_we = 1'b1;
                     end
                     btc_pkg::CP_MOVE_TO_CTRL: begin
                        next_cp_sel = sel;
                        next_cp_reg = rd_field;
                        next_cp_wdata = SECOND_SRC_DATA;
                        next_cp_ctrl_we = 1'b1;
                     end
                     btc_pkg::CP_MOVE_FROM_DATA: begin
                        next_cp_sel = sel;
                        next_cp_reg = rd_field;
                        next_cp_data_re = 1'b1;
                        next_rd_pend = 1'b1;
                        next_rd_target = ss;
                     end
                     btc_pkg::CP_MOVE_FROM_CTRL: begin
                        next_cp_sel = sel;
                        next_cp_reg = rd_field;
                        next_cp_ctrl_re = 1'b1;
                        next_rd_pend = 1'b1;
                        next_rd_target = ss;
                     end
                     btc_pkg::CP_BRANCH: begin
                        // Plain forms: the slot always executes
                        if (ss == btc_pkg::CP_BR_TRUE) begin
                           next_branch_taken = cond_now;
                           next_branch_target = dest;
                        end else if (ss == btc_pkg::CP_BR_FALSE) begin
                           next_branch_taken = !cond_now;
                           next_branch_target = dest;
                        end
                     end
                     default: begin
                        next_rd_pend = 1'b0;
                     end
                  endcase
               end
            end
         endcase
      end
   end

   // Register stage; all values reset to constants
   always_ff @(posedge CLK_SYS or negedge RSTN) begin
      if (!RSTN) begin
         rd_pend <= 1'b0;
         rd_target <= 5'h00;
         BRANCH_TAKEN <= 1'b0;
         BRANCH_TARGET <= btc_pkg::RESET_WORD;
         NULLIFY_SLOT <= 1'b0;
         GPR_WE <= 1'b0;
         GPR_WADDR <= 5'h00;
         GPR_WDATA <= btc_pkg::RESET_WORD;
         EXC_SYSTEM_CALL_TRAP <= 1'b0;
         EXC_BREAKPOINT <= 1'b0;
         EXC_DEBUG <= 1'b0;
         TRAP_CODE <= 20'h00000;
         CP_SEL <= 2'h0;
         CP_REG <= 5'h00;
         CP_DATA_WE <= 1'b0;
         CP_CTRL_WE <= 1'b0;
         CP_DATA_RE <= 1'b0;
         CP_CTRL_RE <= 1'b0;
         CP_WDATA <= btc_pkg::RESET_WORD;
         CP_OP_VALID <= 1'b0;
         CP_OP <= 25'h0000000;
      end else begin
         rd_pend <= next_rd_pend;
         rd_target <= next_rd_target;
         BRANCH_TAKEN <= next_branch_taken;
         BRANCH_TARGET <= next_branch_target;
         NULLIFY_SLOT <= next_nullify_slot;
         GPR_WE <= next_gpr_we;
         GPR_WADDR <= next_gpr_waddr;
         GPR_WDATA <= next_gpr_wdata;
         EXC_SYSTEM_CALL_TRAP <= next_exc_system_call_trap;
         EXC_BREAKPOINT <= next_exc_breakpoint;
         EXC_DEBUG <= next_exc_debug;
         TRAP_CODE <= next_trap_code;
         CP_SEL <= next_cp_sel;
         CP_REG <= next_cp_reg;
         CP_DATA_WE <= next_cp_data_we;
         CP_CTRL_WE <= next_cp_ctrl_we;
         CP_DATA_RE <= next_cp_data_re;
         CP_CTRL_RE <= next_cp_ctrl_re;
         CP_WDATA <= next_cp_wdata;
         CP_OP_VALID <= next_cp_op_valid;
         CP_OP <= next_cp_op;
      end
   end

endmodule
`default_nettype wire

// [tb/btc_exec_monitor.sv]
`default_nettype none
module btc_exec_monitor #(
   parameter int NUM_CP = 4
) (
   input wire logic CLK_SYS,
   input wire logic RSTN,
   input wire logic INSTR_VALID,
   input wire logic INSTR_READY,
   input wire logic [31:0] INSTR_WORD,
   input wire logic [31:0] INSTR_ADDR,
   input wire logic [31:0] FIRST_SRC_DATA,
   input wire logic [31:0] SECOND_SRC_DATA,
   input wire logic [NUM_CP-1:0] CP_COND,
   input wire logic [31:0] CP_RDATA,
   input wire logic BRANCH_TAKEN,
   input wire logic [31:0] BRANCH_TARGET,
   input wire logic NULLIFY_SLOT,
   input wire logic GPR_WE,
   input wire logic [4:0] GPR_WADDR,
   input wire logic [31:0] GPR_WDATA,
   input wire logic EXC_SYSTEM_CALL_TRAP,
   input wire logic EXC_BREAKPOINT,
   input wire logic [19:0] TRAP_CODE,
   input wire logic CP_DATA_RE,
   input wire logic CP_CTRL_WE,
   input wire logic [4:0] CP_REG,
   input wire logic [31:0] CP_WDATA,
   input wire logic CP_OP_VALID,
   input wire logic [24:0] CP_OP
);
   // ----------------------------------------
   // Decode helpers
   // ----------------------------------------
   logic take, cop, same, cond;
   logic [4:0] sub, creg;
   logic [19:0] code;
   logic [24:0] cofun;
   logic [31:0] tgt, link;
   // Out-of-range unit numbers are gated off through cop
   assign take = INSTR_VALID && INSTR_READY;
   assign cop = take && INSTR_WORD[31:28] == btc_pkg::OP_COPROC_HI
      && INSTR_WORD[27:26] < NUM_CP;
   assign sub = INSTR_WORD[25:21];
   assign creg = INSTR_WORD[15:11];
   assign code = INSTR_WORD[25:6];
   assign cofun = INSTR_WORD[24:0];
   assign same = FIRST_SRC_DATA == SECOND_SRC_DATA;
   assign cond = CP_COND[INSTR_WORD[27:26]];
   assign tgt = INSTR_ADDR + 32'h0000_0004
      + {{14{INSTR_WORD[15]}}, INSTR_WORD[15:0], 2'h0};
   assign link = INSTR_ADDR + 32'h0000_0008;
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   // ----------------------------------------
   // Sequences
   // ----------------------------------------
   sequence s_trap(logic [5:0] fn);
      take && INSTR_WORD[31:26] == 6'h00 && INSTR_WORD[5:0] == fn;
   endsequence
   // Read pulse stalls decode, data lands one cycle later
   sequence s_rd_done;
      CP_DATA_RE && !INSTR_READY ##1 GPR_WE && GPR_WDATA == $past(CP_RDATA);
   endsequence
   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   system_call_trap_trap_a: assert property (
      s_trap(btc_pkg::FN_SYSTEM_CALL_TRAP) |=> EXC_SYSTEM_CALL_TRAP && !EXC_BREAKPOINT
      && TRAP_CODE == $past(code)) else $error("system_call_trap trap wrong");
   break_trap_a: assert property (
      s_trap(btc_pkg::FN_BREAK) |=> EXC_BREAKPOINT && !EXC_SYSTEM_CALL_TRAP
      && TRAP_CODE == $past(code)) else $error("break trap wrong");
   equal_branch_a: assert property (
      take && INSTR_WORD[31:26] == btc_pkg::OP_EQ_LIKELY |=>
      BRANCH_TAKEN == $past(same) && NULLIFY_SLOT != BRANCH_TAKEN
      && BRANCH_TARGET == $past(tgt)) else $error("equal branch wrong");
   link_write_a: assert property (
      take && INSTR_WORD[31:26] == btc_pkg::OP_REGIMM
      && INSTR_WORD[20:17] == 4'h9 |=> GPR_WE
      && GPR_WADDR == btc_pkg::LINK_REGISTER && GPR_WDATA == $past(link))
      else $error("link write wrong");
   move_read_a: assert property (
      cop && sub == btc_pkg::CP_MOVE_FROM_DATA |=> s_rd_done)
      else $error("coprocessor read wrong");
   move_ctrl_a: assert property (
      cop && sub == btc_pkg::CP_MOVE_TO_CTRL |=> CP_CTRL_WE
      && CP_WDATA == $past(SECOND_SRC_DATA) && CP_REG == $past(creg))
      else $error("control write wrong");
   cop_branch_a: assert property (
      cop && sub == btc_pkg::CP_BRANCH
      && INSTR_WORD[20:16] == btc_pkg::CP_BR_TRUE |=>
      BRANCH_TAKEN == $past(cond) && !NULLIFY_SLOT
      && BRANCH_TARGET == $past(tgt)) else $error("coproc branch wrong");
   cop_op_a: assert property (
      cop && INSTR_WORD[25] |=> CP_OP_VALID && CP_OP == $past(cofun)
      && !GPR_WE && !BRANCH_TAKEN) else $error("coproc op wrong");
endmodule
bind btc_exec btc_exec_monitor #(.NUM_CP(NUM_CP)) i_mon (
   .CLK_SYS(CLK_SYS), .RSTN(RSTN), .INSTR_VALID(INSTR_VALID),
   .INSTR_READY(INSTR_READY), .INSTR_WORD(INSTR_WORD),
   .INSTR_ADDR(INSTR_ADDR), .FIRST_SRC_DATA(FIRST_SRC_DATA),
   .SECOND_SRC_DATA(SECOND_SRC_DATA), .CP_COND(CP_COND),
   .CP_RDATA(CP_RDATA), .BRANCH_TAKEN(BRANCH_TAKEN),
   .BRANCH_TARGET(BRANCH_TARGET), .NULLIFY_SLOT(NULLIFY_SLOT),
   .GPR_WE(GPR_WE), .GPR_WADDR(GPR_WADDR), .GPR_WDATA(GPR_WDATA),
   .EXC_SYSTEM_CALL_TRAP(EXC_SYSTEM_CALL_TRAP), .EXC_BREAKPOINT(EXC_BREAKPOINT),
   .TRAP_CODE(TRAP_CODE), .CP_DATA_RE(CP_DATA_RE),
   .CP_CTRL_WE(CP_CTRL_WE), .CP_REG(CP_REG), .CP_WDATA(CP_WDATA),
   .CP_OP_VALID(CP_OP_VALID), .CP_OP(CP_OP));
`default_nettype wire

// [tb/btc_cop_model.sv]
`default_nettype none
module btc_cop_model #(
   parameter int NUM_CP = 4
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic [NUM_CP-1:0] cond_req,
   input wire logic [1:0] sel,
   input wire logic [4:0] reg_num,
   input wire logic data_we,
   input wire logic ctrl_we,
   input wire logic data_re,
   input wire logic ctrl_re,
   input wire logic [31:0] wdata,
   input wire logic op_valid,
   input wire logic [24:0] op,
   output logic [NUM_CP-1:0] cond,
   output logic [31:0] rdata
);
   logic [31:0] dreg [4][32];
   logic [31:0] creg [4][32];
   logic [31:0] last_rd;
   logic [24:0] last_op;
   // Bench changes the condition only between instructions
   assign cond = cond_req;
   // Idle bus shows the inverse of the last value, never a stale match
   assign rdata = data_re ? dreg[sel][reg_num]
      : ctrl_re ? creg[sel][reg_num] : ~last_rd;
   // Register files and the operation sink
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         last_rd <= 32'h0000_0000;
         last_op <= 25'h0000000;
      end else begin
         if (data_we) dreg[sel][reg_num] <= wdata;
         if (ctrl_we) creg[sel][reg_num] <= wdata;
         if (data_re || ctrl_re) last_rd <= rdata;
         if (op_valid) last_op <= op;
      end
   end
endmodule
`default_nettype wire

// [tb/btc_exec_tb_top.sv]
`default_nettype none
module btc_exec_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int NCP = 3;
   typedef struct {
      logic [31:0] w, a, b;
      logic [2:0] c;
      logic tk, nl, lk;
      logic [2:0] ex;
   } btc_row_s;
   logic clk_sys, rstn, valid, ready, taken, nullify, gpr_we;
   logic exc_sc, exc_bk, exc_db, d_we, c_we, d_re, c_re, op_v;
   logic [31:0] word, addr, src_a, src_b, rdata, target, gpr_wdata, wdata;
   logic [NCP-1:0] cond, cond_req;
   logic [4:0] gpr_waddr, creg;
   logic [19:0] code;
   logic [1:0] sel;
   logic [24:0] op;
   int err_count, comparisons;
   btc_row_s rows[26];
   btc_exec #(.NUM_CP(NCP)) i_dut (.CLK_SYS(clk_sys), .RSTN(rstn),
      .INSTR_VALID(valid), .INSTR_WORD(word), .INSTR_ADDR(addr),
      .FIRST_SRC_DATA(src_a), .SECOND_SRC_DATA(src_b), .CP_COND(cond),
      .CP_RDATA(rdata), .INSTR_READY(ready), .BRANCH_TAKEN(taken),
      .BRANCH_TARGET(target), .NULLIFY_SLOT(nullify), .GPR_WE(gpr_we),
      .GPR_WADDR(gpr_waddr), .GPR_WDATA(gpr_wdata), .EXC_SYSTEM_CALL_TRAP(exc_sc),
      .EXC_BREAKPOINT(exc_bk), .EXC_DEBUG(exc_db), .TRAP_CODE(code),
      .CP_SEL(sel), .CP_REG(creg), .CP_DATA_WE(d_we), .CP_CTRL_WE(c_we),
      .CP_DATA_RE(d_re), .CP_CTRL_RE(c_re), .CP_WDATA(wdata),
      .CP_OP_VALID(op_v), .CP_OP(op));
   btc_cop_model #(.NUM_CP(NCP)) i_cop (.clk(clk_sys), .rstn(rstn),
      .cond_req(cond_req), .sel(sel), .reg_num(creg), .data_we(d_we),
      .ctrl_we(c_we), .data_re(d_re), .ctrl_re(c_re), .wdata(wdata),
      .op_valid(op_v), .op(op), .cond(cond), .rdata(rdata));
   // ----------------------------------------
   // Helpers
   // ----------------------------------------
   function automatic logic [31:0] enc(logic [5:0] o, logic [4:0] s,
      logic [4:0] t, logic [15:0] f);
      return {o, s, t, f};
   endfunction
   function automatic logic [31:0] tgt(logic [31:0] w, logic [31:0] a);
      return a + 32'h0000_0004 + {{14{w[15]}}, w[15:0], 2'h0};
   endfunction
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      comparisons++;
      if (g !== e) begin
         err_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Holds the request until an edge that sees ready high; valid stays
   // up after it, so back-to-back calls never toggle it in one step
   task automatic issue(logic [31:0] w, logic [31:0] a, logic [31:0] b);
      logic r;
      word = w;
      src_a = a;
      src_b = b;
      valid = 1'b1;
      forever begin
         r = ready;
         @(posedge clk_sys);
         if (r === 1'b1) break;
         #10;
      end
      #10;
   endtask
   task automatic report_and_stop;
      $display("comparisons %0d err_count %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // ----------------------------------------
   // Clock and watchdog
   // ----------------------------------------
   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   // About fifty cycles are expected; a hang stops far later
   initial begin
      #(5000 * 100);
      err_count++;
      report_and_stop();
   end
   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial begin
      rstn = 1'b0;
      valid = 1'b0;
      word = 32'h0000_0000;
      addr = 32'h0000_0000;
      src_a = 32'h0000_0000;
      src_b = 32'h0000_0000;
      cond_req = 3'h0;
      err_count = 0;
      comparisons = 0;
      rows = '{
         '{enc(6'h14, 1, 2, 16'h0010), 5, 5, 0, 1, 0, 0, 0},
         '{enc(6'h14, 1, 2, 16'hFFF8), 5, 6, 0, 0, 1, 0, 0},
         '{enc(6'h15, 1, 2, 16'hFFF8), 5, 6, 0, 1, 0, 0, 0},
         '{enc(6'h15, 1, 2, 16'h0010), 7, 7, 0, 0, 1, 0, 0},
         '{enc(6'h16, 3, 0, 16'h0004), 0, 0, 0, 1, 0, 0, 0},
         '{enc(6'h16, 3, 0, 16'h0004), 1, 0, 0, 0, 1, 0, 0},
         '{enc(6'h16, 3, 0, 16'h8000), 32'h8000_0000, 0, 0, 1, 0, 0, 0},
         '{enc(6'h17, 3, 0, 16'h7FFF), 1, 0, 0, 1, 0, 0, 0},
         '{enc(6'h17, 3, 0, 16'h7FFF), 0, 0, 0, 0, 1, 0, 0},
         '{enc(6'h17, 3, 0, 16'h0020), 32'hFFFF_FFFF, 0, 0, 0, 1, 0, 0},
         '{enc(6'h01, 4, 5'h02, 16'h0008), 32'h8000_0000, 0, 0, 1, 0, 0, 0},
         '{enc(6'h01, 4, 5'h02, 16'h0008), 0, 0, 0, 0, 1, 0, 0},
         '{enc(6'h01, 4, 5'h03, 16'hFFFF), 0, 0, 0, 1, 0, 0, 0},
         '{enc(6'h01, 4, 5'h03, 16'hFFFF), 32'hFFFF_FFFF, 0, 0, 0, 1, 0, 0},
         '{enc(6'h01, 4, 5'h03, 16'h0001), 32'h7FFF_FFFF, 0, 0, 1, 0, 0, 0},
         '{enc(6'h01, 4, 5'h12, 16'h0040), 32'hFFFF_FFFF, 0, 0, 1, 0, 1, 0},
         '{enc(6'h01, 4, 5'h12, 16'h0040), 0, 0, 0, 0, 1, 1, 0},
         '{enc(6'h01, 4, 5'h13, 16'hFF00), 0, 0, 0, 1, 0, 1, 0},
         '{enc(6'h01, 4, 5'h13, 16'hFF00), 32'h8000_0000, 0, 0, 0, 1, 1, 0},
         '{{6'h00, 20'hA5A5A, 6'h0C}, 0, 0, 0, 0, 0, 0, 3'h4},
         '{{6'h00, 20'h5A5A5, 6'h0D}, 0, 0, 0, 0, 0, 0, 3'h2},
         '{{6'h00, 20'hFFFFF, 6'h0E}, 0, 0, 0, 0, 0, 0, 3'h1},
         '{enc(6'h11, 5'h08, 5'h01, 16'hFFF0), 0, 0, 3'h2, 1, 0, 0, 0},
         '{enc(6'h11, 5'h08, 5'h01, 16'hFFF0), 0, 0, 3'h5, 0, 0, 0, 0},
         '{enc(6'h12, 5'h08, 5'h00, 16'h0100), 0, 0, 3'h3, 1, 0, 0, 0},
         '{enc(6'h12, 5'h08, 5'h00, 16'h0100), 0, 0, 3'h4, 0, 0, 0, 0}};
      // Outputs are only defined once an edge has seen reset
      repeat (2) @(posedge clk_sys);
      #10 chk("ready in reset", 1, ready);
      chk("taken in reset", 0, taken);
      rstn = 1'b1;
      // Table rows, issued back to back
      foreach (rows[i]) begin
         cond_req = rows[i].c;
         addr = 32'h0000_4000 + 32'(i) * 32'h0000_0010;
         issue(rows[i].w, rows[i].a, rows[i].b);
         chk("taken", rows[i].tk, taken);
         chk("nullify", rows[i].nl, nullify);
         chk("link we", rows[i].lk, gpr_we);
         chk("trap", rows[i].ex, {exc_sc, exc_bk, exc_db});
         if (rows[i].ex != 3'h0) begin
            chk("code", rows[i].w[25:6], code);
         end else begin
            chk("target", tgt(rows[i].w, addr), target);
         end
         if (rows[i].lk) chk("link", addr + 32'h8, gpr_wdata);
      end
      // Moves per unit; a trap waits out the read stall
      for (int s = 0; s < NCP; s++) begin
         issue({4'h4, 2'(s), 5'h04, 5'h03, 5'h09, 11'h0}, 0, 32'hC0DE_0000 + s);
         chk("data we", 1, d_we);
         chk("sel", s, sel);
         issue({4'h4, 2'(s), 5'h06, 5'h03, 5'h0A, 11'h0}, 0, 32'h5EED_0000 + s);
         chk("ctrl we", 1, c_we);
         issue({4'h4, 2'(s), 5'h00, 5'h07, 5'h09, 11'h0}, 0, 0);
         chk("stall", 0, ready);
         issue({6'h00, 20'h0000F, 6'h0C}, 0, 0);
         chk("read data", 32'hC0DE_0000 + s, gpr_wdata);
         chk("read reg", 7, gpr_waddr);
         chk("one trap", 1, exc_sc);
         issue({4'h4, 2'(s), 5'h02, 5'h08, 5'h0A, 11'h0}, 0, 0);
         @(posedge clk_sys);
         #10 chk("ctrl read", 32'h5EED_0000 + s, gpr_wdata);
         chk("ctrl reg", 8, gpr_waddr);
         chk("trap gone", 0, exc_sc);
      end
      issue({4'h4, 2'h2, 1'b1, 25'h0ABCDE1}, 0, 0);
      chk("op", 25'h0ABCDE1, op);
      chk("op quiet", 3'h4, {op_v, gpr_we, taken});
      issue({4'h4, 2'h3, 5'h04, 5'h03, 5'h09, 11'h0}, 0, 1);
      chk("refused", 0, d_we);
      chk("op sink", 25'h0ABCDE1, i_cop.last_op);
      // Reset in mid-run clears the pulses at once
      issue(rows[0].w, 5, 5);
      rstn = 1'b0;
      #10 chk("reset taken", 0, taken);
      chk("reset ready", 1, ready);
      // Release again; the first edge after it takes a request
      @(posedge clk_sys);
      #10 rstn = 1'b1;
      issue(rows[1].w, 5, 6);
      chk("after reset", 1, nullify);
      report_and_stop();
   end
endmodule
`default_nettype wire
